// ---- qbp_pkg.sv ----
/*
 Shared constants and carrier types for the quasi-bidirectional port block.
 Assumes one 100 MHz clock; peripheral outputs idle high when unused.
*/
`default_nettype none
package qbp_pkg;
	// ==========================================================
	// Pin layout: P2.4-P2.7, then ports 3, 4 and 5
	localparam int QBP_PORT_W = 8;
	localparam int QBP_P2_W   = 4;
	localparam int QBP_P2_LSB = 4;
	localparam int QBP_NPINS  = 28;
	localparam int QBP_P2_BASE = 0;
	localparam int QBP_P3_BASE = 4;
	localparam int QBP_P4_BASE = 12;
	localparam int QBP_P5_BASE = 20;
	// ==========================================================
	// Alternate function bit positions
	localparam int QBP_P3_SER_RX = 0;
	localparam int QBP_P3_SER_TX = 1;
	localparam int QBP_P3_IRQ0   = 2;
	localparam int QBP_P3_IRQ1   = 3;
	localparam int QBP_P3_TMR0   = 4;
	localparam int QBP_P3_TMR1   = 5;
	localparam int QBP_P3_WRS    = 6;
	localparam int QBP_P3_RDS    = 7;
	localparam int QBP_P4_CS_LSB = 0;
	localparam int QBP_P4_AD_LSB = 4;
	localparam int QBP_P5_CAN_TX = 0;
	localparam int QBP_P5_CAN_RX = 1;
	localparam int QBP_P5_TMR3   = 2;
	localparam int QBP_P5_PS_LSB = 4;
	localparam int QBP_GRP_W     = 4;
	// ==========================================================
	// Reset values and timing
	localparam logic QBP_LATCH_RST = 1'h1;
	localparam logic QBP_IDLE      = 1'h1;
	localparam int QBP_CLK_MHZ  = 100;
	localparam int QBP_PULSE_NS = 20;
	localparam int QBP_PULSE_CYC = (QBP_PULSE_NS * QBP_CLK_MHZ + 999) / 1000;
	localparam int QBP_SYNC_LAT = 3;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		QBP_SEL_P2 = 2'h0,
		QBP_SEL_P3 = 2'h1,
		QBP_SEL_P4 = 2'h2,
		QBP_SEL_P5 = 2'h3
	} qbp_port_t;
	typedef struct packed {
		logic                  en;
		qbp_port_t             sel;
		logic [QBP_PORT_W-1:0] data;
	} qbp_wr_t;
	typedef struct packed {
		logic                 serial_zero_transmit_out;
		logic                 timer_one_clock_out;
		logic                 timer_one_clock_out_en;
		logic                 ext_data_write_n;
		logic                 ext_data_read_n;
		logic                 ext_mem_active;
		logic [QBP_GRP_W-1:0] p2_addr;
		logic [QBP_GRP_W-1:0] upper_addr;
		logic [QBP_GRP_W-1:0] program_chip_select_n;
		logic                 can_transmit_line;
		logic [QBP_GRP_W-1:0] peripheral_select_n;
	} qbp_alt_src_t;
	typedef struct packed {
		logic serial_zero_receive_in;
		logic ext_irq_zero_in;
		logic ext_irq_one_in;
		logic timer_zero_count_in;
		logic timer_one_in_or_clock_out;
		logic can_receive_line;
		logic timer_three_count_in;
	} qbp_alt_snk_t;
	typedef struct packed {
		logic [QBP_NPINS-1:0] o;
		logic [QBP_NPINS-1:0] oe_n;
	} qbp_pads_t;
endpackage : qbp_pkg
`default_nettype wire

// ---- qbp_pin.sv ----
/*
 One quasi-bidirectional pin: port latch, strong pulldown, momentary
 strong pull-up and a two-stage input synchroniser.
 Assumes the pad has a permanent weak pullup outside this logic.
*/
`timescale 1ns/1ps
`default_nettype none
module qbp_pin #(
	parameter int PULSE_CYC = qbp_pkg::QBP_PULSE_CYC
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// Latch write and alternate output
	input  wire logic wr_en,
	input  wire logic wr_bit,
	input  wire logic alt_val,
	// Pad
	input  wire logic pad_i,
	output logic      pad_o,
	output logic      pad_oe_n,
	// Read back
	output logic      latch_q,
	output logic      pin_lvl
);
	import qbp_pkg::*;
	localparam int CW = $clog2(PULSE_CYC + 1);

	logic          latch_r;
	logic          latch_nxt;
	logic          eff;
	logic          eff_r;
	logic          rise;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          o_r;
	logic          o_nxt;
	logic          oe_n_r;
	logic          oe_n_nxt;
	logic          sync1_r;
	logic          sync2_r;
	logic [CW:0]   hi_run_r;

	// ==========================================================
	// Drive control
	always_comb
	begin
		latch_nxt = wr_en ? wr_bit : latch_r;
		// Alternate function is ANDed in so a latch of one passes it
		eff       = latch_r & alt_val; // R15
		rise      = eff & ~eff_r;
		cnt_nxt   = cnt_r;
		o_nxt     = 1'h1;
		oe_n_nxt  = 1'h1;
		if (!eff)
		begin
			o_nxt    = 1'h0; // R3
			oe_n_nxt = 1'h0; // R3
			cnt_nxt  = {CW{1'h0}};
		end
		else if (rise)
		begin
			oe_n_nxt = 1'h0; // R4
			cnt_nxt  = CW'(PULSE_CYC - 1);
		end
		else if (cnt_r != {CW{1'h0}})
		begin
			oe_n_nxt = 1'h0; // R4
			cnt_nxt  = cnt_r - 1'h1;
		end
	end

	// eff_r resets high so leaving reset gives no pull-up pulse
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			latch_r <= QBP_LATCH_RST; // R1
			eff_r   <= QBP_LATCH_RST;
			cnt_r   <= {CW{1'h0}};
			o_r     <= 1'h1;
			oe_n_r  <= 1'h1; // R1
			sync1_r <= 1'h1;
			sync2_r <= 1'h1;
		end
		else
		begin
			latch_r <= latch_nxt;
			eff_r   <= eff;
			cnt_r   <= cnt_nxt;
			o_r     <= o_nxt;
			oe_n_r  <= oe_n_nxt;
			sync1_r <= pad_i; // R2
			sync2_r <= sync1_r;
		end
	end

	assign pad_o    = o_r;
	assign pad_oe_n = oe_n_r;
	assign latch_q  = latch_r;
	assign pin_lvl  = sync2_r;

	// ==========================================================
	// Checks
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			hi_run_r <= {(CW+1){1'h0}};
		else if (!oe_n_r && o_r)
			hi_run_r <= hi_run_r + 1'h1;
		else
			hi_run_r <= {(CW+1){1'h0}};
	end

	property p_reset_weak;
		@(posedge mclk) $rose(reset_n) |-> (pad_oe_n && latch_q);
	endproperty
	a_reset_weak: assert property (p_reset_weak) else $error("pin not weak high after reset"); // R1

	property p_input_seen;
		@(posedge mclk) disable iff (!reset_n) $past(reset_n) && $past(reset_n, 2) |-> pin_lvl == $past(pad_i, 2);
	endproperty
	a_input_seen: assert property (p_input_seen) else $error("pin level not two cycles behind pad"); // R2

	property p_zero_hold;
		@(posedge mclk) disable iff (!reset_n) !latch_q |=> (!pad_oe_n && !pad_o);
	endproperty
	a_zero_hold: assert property (p_zero_hold) else $error("latch zero without strong pulldown"); // R3

	property p_one_pulse;
		@(posedge mclk) disable iff (!reset_n) rise |=> (!pad_oe_n && pad_o);
	endproperty
	a_one_pulse: assert property (p_one_pulse) else $error("no strong pull-up after rise"); // R4

	property p_pulse_len;
		@(posedge mclk) disable iff (!reset_n) hi_run_r <= (CW+1)'(PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("strong pull-up held too long"); // R4

	c_pulse: cover property (@(posedge mclk) disable iff (!reset_n) rise ##1 (!pad_oe_n && pad_o));
endmodule : qbp_pin
`default_nettype wire

// ---- qbp_port.sv ----
/*
 Quasi-bidirectional ports P2.4-P2.7, P3, P4 and P5 with alternate
 function routing to serial, timer, interrupt, memory and CAN logic.
 Assumes latch writes and peripheral signals are on mclk; pads are async.
*/
// Functional notes
// (R1) Reset puts every port bit high, held only by the weak pullup.
// (R2) A weakly high pin is an input; outside circuits may pull it low.
// (R3) Writing zero turns on a strong pulldown until one is written or reset.
// (R4) Writing one after zero gives a brief strong pull-up, then weak high.
// (R5) Port four config picks I/O or memory signal for each pin.
// (R6) P3.0 is serial zero receive, P3.1 serial zero transmit.
// (R7) P3.2 and P3.3 feed external interrupts zero and one.
// (R8) P3.4 is timer zero input; P3.5 timer one input or clock output.
// (R9) P3.6 carries external data write strobe, P3.7 read strobe.
// (R10) P4.0-P4.3 in memory mode drive program chip selects zero to three.
// (R11) P4.4-P4.7 in memory mode drive address bits sixteen to nineteen.
// (R12) P2.4-P2.7 carry address bits twelve to fifteen in external accesses.
// (R13) P5.0 is CAN transmit, P5.1 CAN receive; absent without CAN.
// (R14) P5.2 is timer three input; P5.4-P5.7 drive peripheral selects.
// (R15) Alternate output is ANDed with the latch so a one passes it.
`timescale 1ns/1ps
`default_nettype none
module qbp_port #(
	parameter bit HAS_CAN   = 1'b1,
	parameter int PULSE_CYC = qbp_pkg::QBP_PULSE_CYC
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          reset_n,
	// Latch write and configuration
	input  wire qbp_pkg::qbp_wr_t              wr,
	input  wire logic [qbp_pkg::QBP_PORT_W-1:0] port_four_config,
	// Peripheral side
	input  wire qbp_pkg::qbp_alt_src_t         alt_src,
	output qbp_pkg::qbp_alt_snk_t              alt_snk,
	// Pads
	input  wire logic [qbp_pkg::QBP_NPINS-1:0] pad_i,
	output qbp_pkg::qbp_pads_t                 pads,
	// Read back
	output logic [qbp_pkg::QBP_NPINS-1:0]      latch_q,
	output logic [qbp_pkg::QBP_NPINS-1:0]      pin_lvl
);
	import qbp_pkg::*;

	logic [QBP_NPINS-1:0] wr_en;
	logic [QBP_NPINS-1:0] wr_bit;
	logic [QBP_NPINS-1:0] alt_val;
	qbp_alt_snk_t         snk_r;
	qbp_alt_snk_t         snk_nxt;

	// ==========================================================
	// Latch write decode
	always_comb
	begin
		wr_en  = {QBP_NPINS{1'h0}};
		wr_bit = {QBP_NPINS{1'h1}};
		for (int i = 0; i < QBP_P2_W; i++)
		begin
			wr_en[QBP_P2_BASE+i]  = wr.en && (wr.sel == QBP_SEL_P2);
			wr_bit[QBP_P2_BASE+i] = wr.data[QBP_P2_LSB+i];
		end
		for (int i = 0; i < QBP_PORT_W; i++)
		begin
			wr_en[QBP_P3_BASE+i]  = wr.en && (wr.sel == QBP_SEL_P3);
			wr_bit[QBP_P3_BASE+i] = wr.data[i];
			wr_en[QBP_P4_BASE+i]  = wr.en && (wr.sel == QBP_SEL_P4);
			wr_bit[QBP_P4_BASE+i] = wr.data[i];
			wr_en[QBP_P5_BASE+i]  = wr.en && (wr.sel == QBP_SEL_P5);
			wr_bit[QBP_P5_BASE+i] = wr.data[i];
		end
	end

	// ==========================================================
	// Alternate output routing; unused functions sit at the idle level
	always_comb
	begin
		alt_val = {QBP_NPINS{QBP_IDLE}};
		for (int i = 0; i < QBP_GRP_W; i++)
		begin
			if (alt_src.ext_mem_active)
				alt_val[QBP_P2_BASE+i] = alt_src.p2_addr[i]; // R12
			if (port_four_config[QBP_P4_CS_LSB+i]) // R5
				alt_val[QBP_P4_BASE+QBP_P4_CS_LSB+i] = alt_src.program_chip_select_n[i]; // R10
			if (port_four_config[QBP_P4_AD_LSB+i]) // R5
				alt_val[QBP_P4_BASE+QBP_P4_AD_LSB+i] = alt_src.upper_addr[i]; // R11
			alt_val[QBP_P5_BASE+QBP_P5_PS_LSB+i] = alt_src.peripheral_select_n[i]; // R14
		end
		alt_val[QBP_P3_BASE+QBP_P3_SER_TX] = alt_src.serial_zero_transmit_out; // R6
		if (alt_src.timer_one_clock_out_en)
			alt_val[QBP_P3_BASE+QBP_P3_TMR1] = alt_src.timer_one_clock_out; // R8
		alt_val[QBP_P3_BASE+QBP_P3_WRS] = alt_src.ext_data_write_n; // R9
		alt_val[QBP_P3_BASE+QBP_P3_RDS] = alt_src.ext_data_read_n; // R9
		// Without the CAN controller the pin is plain I/O
		if (HAS_CAN)
			alt_val[QBP_P5_BASE+QBP_P5_CAN_TX] = alt_src.can_transmit_line; // R13
	end

	// ==========================================================
	// Pin cells
	genvar g;
	generate
		for (g = 0; g < QBP_NPINS; g++)
		begin : g_pin
			qbp_pin #(
				.PULSE_CYC (PULSE_CYC)
			) u_pin (
				.mclk     (mclk),
				.reset_n  (reset_n),
				.wr_en    (wr_en[g]),
				.wr_bit   (wr_bit[g]),
				.alt_val  (alt_val[g]),
				.pad_i    (pad_i[g]),
				.pad_o    (pads.o[g]),
				.pad_oe_n (pads.oe_n[g]),
				.latch_q  (latch_q[g]),
				.pin_lvl  (pin_lvl[g])
			);
		end
	endgenerate

	// ==========================================================
	// Alternate inputs, taken from the synchronised pin levels
	always_comb
	begin
		snk_nxt.serial_zero_receive_in    = pin_lvl[QBP_P3_BASE+QBP_P3_SER_RX]; // R6
		snk_nxt.ext_irq_zero_in           = pin_lvl[QBP_P3_BASE+QBP_P3_IRQ0]; // R7
		snk_nxt.ext_irq_one_in            = pin_lvl[QBP_P3_BASE+QBP_P3_IRQ1]; // R7
		snk_nxt.timer_zero_count_in       = pin_lvl[QBP_P3_BASE+QBP_P3_TMR0]; // R8
		snk_nxt.timer_one_in_or_clock_out = pin_lvl[QBP_P3_BASE+QBP_P3_TMR1]; // R8
		snk_nxt.timer_three_count_in      = pin_lvl[QBP_P5_BASE+QBP_P5_TMR3]; // R14
		snk_nxt.can_receive_line          = QBP_IDLE;
		if (HAS_CAN)
			snk_nxt.can_receive_line = pin_lvl[QBP_P5_BASE+QBP_P5_CAN_RX]; // R13
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			snk_r <= '1;
		else
			snk_r <= snk_nxt;
	end

	assign alt_snk = snk_r;

	// ==========================================================
	// Checks
	// Input checks wait until the synchronisers hold real samples again
	logic [QBP_SYNC_LAT-1:0] sync_up_r;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			sync_up_r <= {QBP_SYNC_LAT{1'h0}};
		else
			sync_up_r <= {sync_up_r[QBP_SYNC_LAT-2:0], 1'h1};
	end

	property p_ser_tx;
		@(posedge mclk) disable iff (!reset_n)
			!alt_src.serial_zero_transmit_out |=> !pads.o[QBP_P3_BASE+QBP_P3_SER_TX];
	endproperty
	a_ser_tx: assert property (p_ser_tx) else $error("serial transmit zero not driven"); // R6

	property p_irq_in;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.ext_irq_zero_in == $past(pad_i[QBP_P3_BASE+QBP_P3_IRQ0], QBP_SYNC_LAT);
	endproperty
	a_irq_in: assert property (p_irq_in) else $error("interrupt input not three cycles behind pad"); // R7

	property p_tmr1_out;
		@(posedge mclk) disable iff (!reset_n)
			(alt_src.timer_one_clock_out_en && !alt_src.timer_one_clock_out)
			|=> (!pads.o[QBP_P3_BASE+QBP_P3_TMR1] && !pads.oe_n[QBP_P3_BASE+QBP_P3_TMR1]);
	endproperty
	a_tmr1_out: assert property (p_tmr1_out) else $error("clock output low not driven"); // R8

	property p_wr_strobe;
		@(posedge mclk) disable iff (!reset_n)
			!alt_src.ext_data_write_n |=> !pads.o[QBP_P3_BASE+QBP_P3_WRS];
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe not on pin"); // R9

	property p_io_mode;
		@(posedge mclk) disable iff (!reset_n)
			(!port_four_config[QBP_P4_CS_LSB] && latch_q[QBP_P4_BASE+QBP_P4_CS_LSB])
			|=> pads.o[QBP_P4_BASE+QBP_P4_CS_LSB];
	endproperty
	a_io_mode: assert property (p_io_mode) else $error("I/O mode pin taken by memory"); // R5

	property p_chip_sel;
		@(posedge mclk) disable iff (!reset_n)
			(port_four_config[QBP_P4_CS_LSB] && !alt_src.program_chip_select_n[0])
			|=> !pads.o[QBP_P4_BASE+QBP_P4_CS_LSB];
	endproperty
	a_chip_sel: assert property (p_chip_sel) else $error("chip select not on pin"); // R10

	property p_upper_addr;
		@(posedge mclk) disable iff (!reset_n)
			(port_four_config[QBP_P4_AD_LSB] && !alt_src.upper_addr[0])
			|=> !pads.o[QBP_P4_BASE+QBP_P4_AD_LSB];
	endproperty
	a_upper_addr: assert property (p_upper_addr) else $error("address sixteen not on pin"); // R11

	property p_p2_addr;
		@(posedge mclk) disable iff (!reset_n)
			(alt_src.ext_mem_active && !alt_src.p2_addr[0]) |=> !pads.o[QBP_P2_BASE];
	endproperty
	a_p2_addr: assert property (p_p2_addr) else $error("address twelve not on pin"); // R12

	property p_can_tx;
		@(posedge mclk) disable iff (!reset_n)
			(HAS_CAN && !alt_src.can_transmit_line) |=> !pads.o[QBP_P5_BASE+QBP_P5_CAN_TX];
	endproperty
	a_can_tx: assert property (p_can_tx) else $error("CAN transmit not on pin"); // R13

	property p_psel;
		@(posedge mclk) disable iff (!reset_n)
			!alt_src.peripheral_select_n[0] |=> !pads.o[QBP_P5_BASE+QBP_P5_PS_LSB];
	endproperty
	a_psel: assert property (p_psel) else $error("peripheral select not on pin"); // R14

	property p_ser_rx;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.serial_zero_receive_in == $past(pad_i[QBP_P3_BASE+QBP_P3_SER_RX], QBP_SYNC_LAT);
	endproperty
	a_ser_rx: assert property (p_ser_rx) else $error("serial receive not three cycles behind pad"); // R6

	property p_irq1_in;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.ext_irq_one_in == $past(pad_i[QBP_P3_BASE+QBP_P3_IRQ1], QBP_SYNC_LAT);
	endproperty
	a_irq1_in: assert property (p_irq1_in) else $error("second interrupt not three cycles behind pad"); // R7

	property p_tmr0_in;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.timer_zero_count_in == $past(pad_i[QBP_P3_BASE+QBP_P3_TMR0], QBP_SYNC_LAT);
	endproperty
	a_tmr0_in: assert property (p_tmr0_in) else $error("timer zero input not three cycles behind pad"); // R8

	property p_tmr1_in;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.timer_one_in_or_clock_out == $past(pad_i[QBP_P3_BASE+QBP_P3_TMR1], QBP_SYNC_LAT);
	endproperty
	a_tmr1_in: assert property (p_tmr1_in) else $error("timer one input not three cycles behind pad"); // R8

	property p_tmr3_in;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1]
			|-> alt_snk.timer_three_count_in == $past(pad_i[QBP_P5_BASE+QBP_P5_TMR3], QBP_SYNC_LAT);
	endproperty
	a_tmr3_in: assert property (p_tmr3_in) else $error("timer three input not three cycles behind pad"); // R14

	property p_can_rx;
		@(posedge mclk) disable iff (!reset_n)
			sync_up_r[QBP_SYNC_LAT-1] |-> alt_snk.can_receive_line
				== (HAS_CAN ? $past(pad_i[QBP_P5_BASE+QBP_P5_CAN_RX], QBP_SYNC_LAT) : QBP_IDLE);
	endproperty
	a_can_rx: assert property (p_can_rx) else $error("CAN receive wrong"); // R13

	property p_rd_strobe;
		@(posedge mclk) disable iff (!reset_n)
			!alt_src.ext_data_read_n |=> !pads.o[QBP_P3_BASE+QBP_P3_RDS];
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe not on pin"); // R9

	property p_p2_io;
		@(posedge mclk) disable iff (!reset_n)
			(!alt_src.ext_mem_active && latch_q[QBP_P2_BASE]) |=> pads.o[QBP_P2_BASE];
	endproperty
	a_p2_io: assert property (p_p2_io) else $error("address drives pin outside access"); // R12

	property p_tmr1_gate;
		@(posedge mclk) disable iff (!reset_n)
			(!alt_src.timer_one_clock_out_en && latch_q[QBP_P3_BASE+QBP_P3_TMR1])
			|=> pads.o[QBP_P3_BASE+QBP_P3_TMR1];
	endproperty
	a_tmr1_gate: assert property (p_tmr1_gate) else $error("clock output drives pin while off"); // R8

	property p_cs_top;
		@(posedge mclk) disable iff (!reset_n)
			(port_four_config[QBP_P4_CS_LSB+QBP_GRP_W-1] && !alt_src.program_chip_select_n[QBP_GRP_W-1])
			|=> !pads.o[QBP_P4_BASE+QBP_P4_CS_LSB+QBP_GRP_W-1];
	endproperty
	a_cs_top: assert property (p_cs_top) else $error("last chip select not on pin"); // R10

	property p_addr_top;
		@(posedge mclk) disable iff (!reset_n)
			(port_four_config[QBP_P4_AD_LSB+QBP_GRP_W-1] && !alt_src.upper_addr[QBP_GRP_W-1])
			|=> !pads.o[QBP_P4_BASE+QBP_P4_AD_LSB+QBP_GRP_W-1];
	endproperty
	a_addr_top: assert property (p_addr_top) else $error("address nineteen not on pin"); // R11

	property p_psel_top;
		@(posedge mclk) disable iff (!reset_n)
			!alt_src.peripheral_select_n[QBP_GRP_W-1] |=> !pads.o[QBP_P5_BASE+QBP_P5_PS_LSB+QBP_GRP_W-1];
	endproperty
	a_psel_top: assert property (p_psel_top) else $error("last peripheral select not on pin"); // R14

	property p_zero_write;
		@(posedge mclk) disable iff (!reset_n)
			(wr.en && (wr.sel == QBP_SEL_P5) && !wr.data[QBP_P5_PS_LSB])
			|-> ##2 (!pads.oe_n[QBP_P5_BASE+QBP_P5_PS_LSB] && !pads.o[QBP_P5_BASE+QBP_P5_PS_LSB]);
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("written zero not pulled down"); // R3

	property p_reset_pads;
		@(posedge mclk) $rose(reset_n) |-> (&pads.oe_n && &pads.o && &latch_q && &alt_snk);
	endproperty
	a_reset_pads: assert property (p_reset_pads) else $error("port not weak high after reset"); // R1

	c_mem_mode: cover property (@(posedge mclk) disable iff (!reset_n)
		port_four_config[QBP_P4_AD_LSB] && !alt_src.upper_addr[0]);
	c_ext_access: cover property (@(posedge mclk) disable iff (!reset_n)
		alt_src.ext_mem_active && !alt_src.ext_data_read_n);
	c_sw_low: cover property (@(posedge mclk) disable iff (!reset_n)
		wr.en && (wr.sel == QBP_SEL_P3) && (wr.data == 8'h00));
	c_can_tx: cover property (@(posedge mclk) disable iff (!reset_n)
		HAS_CAN && !alt_src.can_transmit_line);
endmodule : qbp_port
`default_nettype wire

// ---- qbp_ext_model.sv ----
/*
 Pin-side partner: weak pullups and outside circuits on every port pin.
 Assumes pads.oe_n low means the device drives pads.o strongly.
*/
`timescale 1ns/1ps
`default_nettype none
module qbp_ext_model (
	// Device pads
	input  wire qbp_pkg::qbp_pads_t            pads,
	// Outside pull-low requests from the bench
	input  wire logic [qbp_pkg::QBP_NPINS-1:0] ext_low,
	// Resolved pin levels
	output logic [qbp_pkg::QBP_NPINS-1:0]      pin
);
	import qbp_pkg::*;
	// ==========================================================
	// Pin resolution
	// Strong drive wins; a released pin sits at the pullup unless pulled low
	always_comb
	begin
		for (int i = 0; i < QBP_NPINS; i++)
			pin[i] = !pads.oe_n[i] ? pads.o[i] : !ext_low[i];
	end
endmodule : qbp_ext_model
`default_nettype wire

// ---- qbp_port_tb.sv ----
/*
 Self-checking bench for the port block with queued expectations.
 Assumes the pin partner resolves pads against outside pull-downs.
*/
`timescale 1ns/1ps
`default_nettype none
module qbp_port_tb;
	import qbp_pkg::*;
	typedef struct {int due; int kind; logic [QBP_NPINS-1:0] exp; logic [QBP_NPINS-1:0] msk;} qbp_note_t;
	localparam int PC = 2;
	// ==========================================================
	// Signals
	logic                  mclk;
	logic                  reset_n;
	qbp_wr_t               wr;
	logic [QBP_PORT_W-1:0] port_four_config;
	qbp_alt_src_t          alt_src;
	qbp_alt_snk_t          alt_snk;
	qbp_pads_t             pads;
	qbp_alt_snk_t          alt_snk_nc;
	qbp_pads_t             pads_nc;
	logic [QBP_NPINS-1:0]  pad_i;
	logic [QBP_NPINS-1:0]  ext_low;
	logic [QBP_NPINS-1:0]  latch_q;
	logic [QBP_NPINS-1:0]  pin_lvl;
	logic [QBP_NPINS-1:0]  lat_m;
	qbp_note_t             q[$];
	int                    cyc = 0;
	int                    error_cnt;
	int                    tests_run;
	int                    seed;
	qbp_port #(.HAS_CAN(1'b1), .PULSE_CYC(PC)) dut (.mclk(mclk), .reset_n(reset_n), .wr(wr),
		.port_four_config(port_four_config), .alt_src(alt_src), .alt_snk(alt_snk), .pad_i(pad_i),
		.pads(pads), .latch_q(latch_q), .pin_lvl(pin_lvl));
	qbp_ext_model ext (.pads(pads), .ext_low(ext_low), .pin(pad_i));
	// Variant without CAN shares the stimulus; its CAN pins must be plain I/O
	qbp_port #(.HAS_CAN(1'b0), .PULSE_CYC(PC)) dut_nc (.mclk(mclk), .reset_n(reset_n), .wr(wr),
		.port_four_config(port_four_config), .alt_src(alt_src), .alt_snk(alt_snk_nc), .pad_i(pad_i),
		.pads(pads_nc), .latch_q(), .pin_lvl());
	always #5 mclk = ~mclk;
	always @(posedge mclk)
		cyc <= cyc + 1;
	// ==========================================================
	// Expected pin values from the current stimulus
	function automatic logic [QBP_NPINS-1:0] alt_m();
		logic [QBP_NPINS-1:0] a;
		a = '1;
		for (int i = 0; i < QBP_GRP_W; i++)
		begin
			if (alt_src.ext_mem_active) a[i] = alt_src.p2_addr[i];
			if (port_four_config[i]) a[12+i] = alt_src.program_chip_select_n[i];
			if (port_four_config[4+i]) a[16+i] = alt_src.upper_addr[i];
			a[24+i] = alt_src.peripheral_select_n[i];
		end
		a[5] = alt_src.serial_zero_transmit_out;
		if (alt_src.timer_one_clock_out_en) a[9] = alt_src.timer_one_clock_out;
		a[10] = alt_src.ext_data_write_n;
		a[11] = alt_src.ext_data_read_n;
		a[20] = alt_src.can_transmit_line;
		return a;
	endfunction : alt_m
	task automatic note(input int d, input int k, input logic [QBP_NPINS-1:0] e, input logic [QBP_NPINS-1:0] m);
		q.push_back('{cyc + d, k, e, m});
	endtask : note
	// Latch, pin level, synchronised level and alternate inputs together
	task automatic settle_chk(input int d);
		logic [QBP_NPINS-1:0] lev;
		lev = lat_m & alt_m() & ~ext_low;
		note(d, 2, lat_m, '1);
		note(d, 0, lev, '1);
		note(d, 3, lev, '1);
		note(d, 4, {lev[4], lev[6], lev[7], lev[8], lev[9], lev[21], lev[22]}, 'h7f);
		note(d, 6, {lat_m[20], 1'b1}, 'h3);
	endtask : settle_chk
	task automatic settle();
		settle_chk(8);
		repeat (9) @(posedge mclk);
	endtask : settle
	task automatic pulse(input logic [QBP_NPINS-1:0] m);
		for (int i = 1; i <= PC; i++)
		begin
			note(i, 1, '0, m);
			note(i, 5, m, m);
		end
		note(PC + 1, 1, '1, m);
	endtask : pulse
	// ==========================================================
	// Drivers
	task automatic wr_port(input qbp_port_t p, input logic [7:0] d);
		@(posedge mclk);
		wr <= '{1'b1, p, d};
		@(posedge mclk);
		wr.en <= 1'b0;
		#1;
		case (p)
			QBP_SEL_P2: lat_m[3:0] = d[7:4];
			QBP_SEL_P3: lat_m[11:4] = d;
			QBP_SEL_P4: lat_m[19:12] = d;
			default: lat_m[27:20] = d;
		endcase
	endtask : wr_port
	task automatic alt_set(input qbp_alt_src_t a, input logic [7:0] c);
		@(posedge mclk);
		alt_src <= a;
		port_four_config <= c;
		#1;
	endtask : alt_set
	task automatic ext_set(input logic [QBP_NPINS-1:0] v);
		@(posedge mclk);
		ext_low <= v;
		#1;
		settle();
	endtask : ext_set
	// ==========================================================
	// Monitor: oldest note against the outputs
	task automatic compare(input qbp_note_t n);
		logic [QBP_NPINS-1:0] got;
		case (n.kind)
			0: got = pad_i;
			1: got = pads.oe_n;
			2: got = latch_q;
			3: got = pin_lvl;
			5: got = pads.o;
			6: got = {{(QBP_NPINS-2){1'b0}}, pads_nc.o[20], alt_snk_nc.can_receive_line};
			default: got = {{(QBP_NPINS-7){1'b0}}, alt_snk};
		endcase
		tests_run++;
		if (n.due != cyc || ((got ^ n.exp) & n.msk) !== '0)
		begin
			error_cnt++;
			$display("BAD %0t kind %0d got %h exp %h", $time, n.kind, got, n.exp);
		end
	endtask : compare
	always @(negedge mclk)
	begin
		while (q.size() > 0 && q[0].due <= cyc)
			compare(q.pop_front());
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (5000) @(posedge mclk);
		error_cnt++;
		$display("BAD %0t run did not finish", $time);
		tally_and_finish();
	end
	// ==========================================================
	// Main sequence
	initial
	begin
		qbp_alt_src_t a;
		logic [31:0]  r;
		logic [31:0]  s;
		int           inp[7];
		inp = '{4, 6, 7, 8, 9, 21, 22};
		mclk = 1'b0;
		reset_n = 1'b0;
		wr = '0;
		port_four_config = '0;
		alt_src = '1;
		ext_low = '0;
		lat_m = '1;
		error_cnt = 0;
		tests_run = 0;
		seed = 32'hbf89;
		repeat (3) @(posedge mclk);
		#1;
		settle_chk(0);
		@(posedge mclk);
		reset_n <= 1'b1;
		wr_port(QBP_SEL_P3, 8'hfe);
		note(1, 1, '0, 'h10);
		settle();
		wr_port(QBP_SEL_P3, 8'hff);
		pulse('h10);
		settle();
		wr_port(QBP_SEL_P3, 8'hff);
		note(1, 1, '1, 'h10);
		settle();
		a = '1;
		a.upper_addr[0] = 1'b0;
		alt_set(a, 8'h10);
		note(1, 1, '0, 'h10000);
		settle();
		a.upper_addr[0] = 1'b1;
		alt_set(a, 8'h10);
		pulse('h10000);
		settle();
		foreach (inp[i])
		begin
			ext_set(28'h1 << inp[i]);
			ext_set('0);
		end
		for (int c = 0; c < 2; c++)
			for (int b = 0; b < $bits(qbp_alt_src_t); b++)
			begin
				alt_set(qbp_alt_src_t'(~(23'h1 << b)), c ? 8'hff : 8'h00);
				settle();
			end
		// A cleared latch must win over an idle-high alternate output
		wr_port(QBP_SEL_P3, 8'h00);
		settle();
		for (int n = 0; n < 40; n++)
		begin
			r = $random(seed);
			s = $random(seed);
			@(posedge mclk);
			alt_src <= r[22:0];
			port_four_config <= r[30:23];
			ext_low <= s[27:0];
			r = $random(seed);
			wr_port(qbp_port_t'(r[1:0]), r[9:2]);
			settle();
		end
		@(posedge mclk);
		alt_src <= '1;
		port_four_config <= '0;
		ext_low <= '0;
		reset_n <= 1'b0;
		lat_m = '1;
		#1;
		settle_chk(0);
		@(posedge mclk);
		reset_n <= 1'b1;
		#1;
		note(1, 1, '1, '1);
		note(2, 1, '1, '1);
		settle();
		for (int i = 0; i < 20 && q.size() > 0; i++)
			@(posedge mclk);
		if (q.size() > 0)
		begin
			error_cnt++;
			$display("BAD %0t notes left unchecked", $time);
		end
		tally_and_finish();
	end
endmodule : qbp_port_tb
`default_nettype wire
